// *** ssd_decoder.sv ***
// ssd_decoder: setup stage descriptor decoder with register port and interrupt
// assumes a descriptor fetcher presents one descriptor per desc_valid pulse
// Notes on behaviour
// - request type, request code and value come from the first dword.
// - index and length come from the second dword, completing eight bytes.
// - transfer length must read eight; setup payload is always eight bytes.
// - interrupter index in third dword bits 31:22 routes events, below count.
// - cycle bit mismatch with expected state means descriptor not yet valid.
// - completion-interrupt flag set means event posted and completion status set; irq raised only if the mask enables it.
// - immediate payload flag must be set; first two dwords are setup data.
// - descriptor type field must be setup stage to dispatch to setup handling.
// - two-bit transfer type gives data stage presence and direction.
`timescale 1ns/10ps
`default_nettype none
module ssd_decoder (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// descriptor input
	input  wire logic        desc_valid,
	input  wire logic [127:0] desc,
	input  wire logic        desc_done,
	// setup handling outputs
	output logic             setup_valid,
	output logic [63:0]      setup_data,
	output logic             data_stage,
	output logic             data_in,
	output logic             event_valid,
	output logic [9:0]       event_intr,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic             irq
);
	ssd_field_if fld ();

	ssd_field_dec u_dec (
		.desc (desc),
		.fld  (fld.producer)
	);

	logic                   ccs;          // expected cycle state
	logic [ssd_pkg::ST_W-1:0] status;
	logic [ssd_pkg::ST_W-1:0] mask;
	logic                   pend_valid;   // setup accepted, awaiting completion
	logic                   pend_irq;
	logic [9:0]             pend_intr;

	// register decode
	wire wr_ctrl   = reg_wr && (reg_addr == ssd_pkg::REG_CTRL);
	wire wr_status = reg_wr && (reg_addr == ssd_pkg::REG_STATUS);
	wire wr_mask   = reg_wr && (reg_addr == ssd_pkg::REG_MASK);

	// acceptance: only a descriptor whose cycle bit matches is owned by us
	wire owned   = desc_valid && (fld.cycle == ccs);
	wire not_val = desc_valid && (fld.cycle != ccs);
	wire good    = owned && fld.fmt_ok && fld.intr_ok
		&& (fld.xtype != ssd_pkg::XT_RESERVED);
	wire bad     = owned && !good;
	wire compl   = desc_done && pend_valid;
	wire post    = compl && pend_irq;

	// event set per cycle; set wins over the write-one clear
	wire [ssd_pkg::ST_W-1:0] ev_set;
	assign ev_set[ssd_pkg::ST_SETUP]   = good;
	assign ev_set[ssd_pkg::ST_NOTVAL]  = not_val;
	assign ev_set[ssd_pkg::ST_BADFMT]  = bad && !(fld.fmt_ok && fld.intr_ok);
	assign ev_set[ssd_pkg::ST_COMPL]   = post;
	assign ev_set[ssd_pkg::ST_BADINTR] = owned && !fld.intr_ok;

	wire [ssd_pkg::ST_W-1:0] clr = wr_status ? reg_wdata[ssd_pkg::ST_W-1:0] : '0;
	wire [ssd_pkg::ST_W-1:0] next_status = (status & ~clr) | ev_set;

	// read mux
	logic [31:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			ssd_pkg::REG_CTRL:     rd_mux = {31'h00000000, ccs};
			ssd_pkg::REG_STATUS:   rd_mux = {27'h0000000, status};
			ssd_pkg::REG_MASK:     rd_mux = {27'h0000000, mask};
			ssd_pkg::REG_SETUP_LO: rd_mux = setup_data[31:0];
			ssd_pkg::REG_SETUP_HI: rd_mux = setup_data[63:32];
			ssd_pkg::REG_INFO:     rd_mux = {20'h00000, pend_intr, pend_valid, pend_irq};
			default:               rd_mux = 32'h00000000;
		endcase
	end

	// cycle state: software may load it when the ring is set up
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ccs <= ssd_pkg::CTRL_RESET[0];
		end else if (wr_ctrl) begin
			ccs <= reg_wdata[0];
		end
	end

	// status and mask
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status <= '0;
			mask   <= '0;
		end else begin
			status <= next_status;
			if (wr_mask) begin
				mask <= reg_wdata[ssd_pkg::ST_W-1:0];
			end
		end
	end

	// setup dispatch: payload is the eight immediate bytes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			setup_valid <= 1'b0;
			setup_data  <= 64'h0000000000000000;
			data_stage  <= 1'b0;
			data_in     <= 1'b0;
		end else begin
			setup_valid <= good;
			if (good) begin
				setup_data <= fld.setup_data;
				data_stage <= fld.xtype[1];
				data_in    <= (fld.xtype == ssd_pkg::XT_IN_DATA);
			end
		end
	end

	// completion tracking: one setup in flight at a time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_valid <= 1'b0;
			pend_irq   <= 1'b0;
			pend_intr  <= 10'h000;
		end else if (good) begin
			pend_valid <= 1'b1;
			pend_irq   <= fld.compl_irq;
			pend_intr  <= fld.intr_target;
		end else if (compl) begin
			pend_valid <= 1'b0;
		end
	end

	// event out routed to the selected interrupter
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			event_valid <= 1'b0;
			event_intr  <= 10'h000;
		end else begin
			event_valid <= post;
			if (post) begin
				event_intr <= pend_intr;
			end
		end
	end

	// read data one cycle after the strobe, zero otherwise; irq registered
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
			irq       <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
			irq       <= |(next_status & mask);
		end
	end
endmodule : ssd_decoder
`default_nettype wire

// *** ssd_pkg.sv ***
// ssd_pkg: constants and types for the setup stage descriptor decoder
// assumes descriptors arrive as four 32-bit dwords, lowest offset first
package ssd_pkg;

	// first dword fields
	localparam int REQTYPE_LSB   = 0;
	localparam int REQUEST_LSB   = 8;
	localparam int VALUE_LSB     = 16;
	// second dword fields
	localparam int INDEX_LSB     = 0;
	localparam int LENGTH_LSB    = 16;
	// third dword fields
	localparam int XFERLEN_LSB   = 0;
	localparam int XFERLEN_W     = 17;
	localparam int INTR_LSB      = 22;
	localparam int INTR_W        = 10;
	// fourth dword fields
	localparam int CYCLE_BIT     = 0;
	localparam int COMPL_IRQ_BIT = 5;
	localparam int IMM_BIT       = 6;
	localparam int TYPE_LSB      = 10;
	localparam int TYPE_W        = 6;
	localparam int XTYPE_LSB     = 16;

	localparam logic [16:0] SETUP_XFER_LEN = 17'h00008;
	localparam logic [5:0]  SETUP_TYPE_ID  = 6'h02; // arbitrary type code, set per system
	localparam logic [9:0]  INTR_COUNT     = 10'h008;

	// register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_MASK    = 8'h08;
	localparam logic [7:0] REG_SETUP_LO = 8'h0C;
	localparam logic [7:0] REG_SETUP_HI = 8'h10;
	localparam logic [7:0] REG_INFO    = 8'h14;
	localparam logic [31:0] CTRL_RESET = 32'h00000001;

	// status bit positions
	localparam int ST_SETUP   = 0;
	localparam int ST_NOTVAL  = 1;
	localparam int ST_BADFMT  = 2;
	localparam int ST_COMPL   = 3;
	localparam int ST_BADINTR = 4;
	localparam int ST_W       = 5;

	typedef enum logic [1:0] {
		XT_NO_DATA,
		XT_RESERVED,
		XT_OUT_DATA,
		XT_IN_DATA
	} ssd_xtype_e;

endpackage : ssd_pkg

// *** ssd_field_if.sv ***
// ssd_field_if: decoded descriptor fields passed from the field decoder
// assumes a single producer and a single consumer in one clock domain
`timescale 1ns/10ps
`default_nettype none
interface ssd_field_if;
	logic [63:0]             setup_data;
	logic [9:0]              intr_target;
	logic                    cycle;
	logic                    compl_irq;
	logic                    fmt_ok;
	logic                    intr_ok;
	ssd_pkg::ssd_xtype_e     xtype;

	modport producer (output setup_data, intr_target, cycle, compl_irq, fmt_ok, intr_ok, xtype);
	modport consumer (input setup_data, intr_target, cycle, compl_irq, fmt_ok, intr_ok, xtype);
endinterface : ssd_field_if
`default_nettype wire

// *** ssd_field_dec.sv ***
// ssd_field_dec: pure decode of one 128-bit setup stage descriptor
// assumes the descriptor words are stable while the caller samples the result
`timescale 1ns/10ps
`default_nettype none
module ssd_field_dec (
	input  wire logic [127:0] desc,
	ssd_field_if.producer     fld
);
	wire [31:0] dw0 = desc[31:0];
	wire [31:0] dw1 = desc[63:32];
	wire [31:0] dw2 = desc[95:64];
	wire [31:0] dw3 = desc[127:96];

	// setup bytes rebuilt in wire order, reserved bits never looked at
	assign fld.setup_data = {dw1[ssd_pkg::LENGTH_LSB +: 16], dw1[ssd_pkg::INDEX_LSB +: 16],
		dw0[ssd_pkg::VALUE_LSB +: 16], dw0[ssd_pkg::REQUEST_LSB +: 8],
		dw0[ssd_pkg::REQTYPE_LSB +: 8]};
	assign fld.intr_target = dw2[ssd_pkg::INTR_LSB +: ssd_pkg::INTR_W];
	assign fld.cycle       = dw3[ssd_pkg::CYCLE_BIT];
	assign fld.compl_irq   = dw3[ssd_pkg::COMPL_IRQ_BIT];
	assign fld.xtype       = ssd_pkg::ssd_xtype_e'(dw3[ssd_pkg::XTYPE_LSB +: 2]);
	// format: fixed length, immediate payload, setup type
	assign fld.fmt_ok = (dw2[ssd_pkg::XFERLEN_LSB +: ssd_pkg::XFERLEN_W] == ssd_pkg::SETUP_XFER_LEN)
		&& dw3[ssd_pkg::IMM_BIT]
		&& (dw3[ssd_pkg::TYPE_LSB +: ssd_pkg::TYPE_W] == ssd_pkg::SETUP_TYPE_ID);
	assign fld.intr_ok = (fld.intr_target < ssd_pkg::INTR_COUNT);
endmodule : ssd_field_dec
`default_nettype wire

// *** ssd_sw_model.sv ***
// ssd_sw_model: software side, packs one setup stage descriptor
// assumes the bench picks fields and may corrupt the result itself
`timescale 1ns/10ps
`default_nettype none
module ssd_sw_model (
	input  wire logic [63:0] setup,
	input  wire logic [1:0]  xtype,
	input  wire logic [9:0]  intr,
	input  wire logic        cyc,
	input  wire logic        compl,
	output logic [127:0]     desc
);
	// setup stage group only; data and status groups follow it on the ring
	// compl is normally clear on a setup stage, the bench sets it to reach events
	// reserved ranges zero, payload inline so no pointer is ever fetched
	assign desc = {14'h0000, xtype, ssd_pkg::SETUP_TYPE_ID, 3'h0, 1'h1, compl, 4'h0, cyc,
		intr, 5'h00, ssd_pkg::SETUP_XFER_LEN, setup};
endmodule : ssd_sw_model
`default_nettype wire

// *** ssd_decoder_monitor.sv ***
// ssd_decoder_monitor: port assertions for ssd_decoder
// assumes a bind onto ssd_decoder, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ssd_decoder_monitor (
	input wire logic         clk_sys,
	input wire logic         rst,
	input wire logic         desc_valid,
	input wire logic [127:0] desc,
	input wire logic         desc_done,
	input wire logic         setup_valid,
	input wire logic [63:0]  setup_data,
	input wire logic         data_stage,
	input wire logic         data_in,
	input wire logic         event_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// accepted descriptor, then any faulty one
	sequence accept_s;
		desc_valid ##1 setup_valid;
	endsequence
	property refuse_p(bad);
		desc_valid && bad |=> !setup_valid;
	endproperty
	AST_CAUSE: assert property (setup_valid |-> $past(desc_valid)) else $error("stray setup");
	AST_BYTES: assert property (accept_s |-> setup_data == $past(desc[63:0]))
		else $error("setup bytes wrong");
	AST_DIR: assert property (accept_s |-> {data_stage, data_in} == {$past(desc[113]),
		$past(desc[113:112]) == 2'h3}) else $error("direction wrong");
	AST_LEN: assert property (refuse_p(desc[80:64] != ssd_pkg::SETUP_XFER_LEN))
		else $error("bad length accepted");
	AST_IMM: assert property (refuse_p(!desc[102])) else $error("pointer form accepted");
	AST_TYPE: assert property (refuse_p(desc[111:106] != ssd_pkg::SETUP_TYPE_ID))
		else $error("bad type accepted");
	AST_INTR: assert property (refuse_p(desc[95:86] >= ssd_pkg::INTR_COUNT))
		else $error("bad interrupter accepted");
	AST_RSVD: assert property (refuse_p(desc[113:112] == 2'h1)) else $error("code 1 accepted");
	AST_EVENT: assert property (event_valid |-> $past(desc_done)) else $error("stray event");
endmodule : ssd_decoder_monitor
bind ssd_decoder ssd_decoder_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .desc_valid(desc_valid),
	.desc(desc), .desc_done(desc_done), .setup_valid(setup_valid), .setup_data(setup_data),
	.data_stage(data_stage), .data_in(data_in), .event_valid(event_valid));
`default_nettype wire

// *** test_ssd_decoder.sv ***
// test_ssd_decoder: table-driven bench for ssd_decoder
// assumes ssd_sw_model builds compliant descriptors
`timescale 1ns/10ps
`default_nettype none
module test_ssd_decoder;
	typedef struct {int fb; logic [1:0] xt; logic [9:0] it; logic cy; logic [4:0] st;} ssd_row_s;
	// fault bit 255 shifts out: clean descriptor
	ssd_row_s rows [10] = '{'{255, 0, 0, 1, 9}, '{255, 2, 3, 1, 9}, '{255, 3, 7, 1, 9},
		'{255, 1, 0, 1, 0}, '{255, 0, 0, 0, 2}, '{64, 0, 0, 1, 4}, '{102, 0, 0, 1, 4},
		'{106, 0, 0, 1, 4}, '{255, 0, 8, 1, 20}, '{120, 0, 0, 1, 9}};
	logic         clk_sys, rst, desc_valid, desc_done, reg_wr, reg_rd, cy, compl;
	logic         setup_valid, data_stage, data_in, event_valid, irq;
	logic [127:0] desc, sw_desc, flt;
	logic [63:0]  setup_data, sd;
	logic [31:0]  reg_wdata, reg_rdata, v;
	logic [9:0]   event_intr, it;
	logic [7:0]   reg_addr;
	logic [1:0]   xt;
	int           errors = 0;
	int           n_checks = 0;
	assign desc = sw_desc ^ flt;
	ssd_sw_model sw (.setup(sd), .xtype(xt), .intr(it), .cyc(cy), .compl(compl), .desc(sw_desc));
	ssd_decoder DUT (.clk_sys(clk_sys), .rst(rst), .desc_valid(desc_valid), .desc(desc),
		.desc_done(desc_done), .setup_valid(setup_valid), .setup_data(setup_data),
		.data_stage(data_stage), .data_in(data_in), .event_valid(event_valid),
		.event_intr(event_intr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	initial begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask : wr
	task automatic send();
		desc_valid <= 1;
		@(posedge clk_sys);
		desc_valid <= 0;
		#1;
	endtask : send
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		complete_run();
	end
	initial begin
		{rst, desc_valid, desc_done, reg_wr, reg_rd, compl, cy} = 7'h43;
		{reg_addr, reg_wdata, flt, xt, it, sd} = '0;
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		foreach (rows[i]) begin
			@(posedge clk_sys);
			flt <= 128'h1 << rows[i].fb;
			{xt, it, cy} <= {rows[i].xt, rows[i].it, rows[i].cy};
			sd <= 64'h8877665544332211 ^ {8{8'(i)}};
			send();
			chk(setup_valid, rows[i].st[0]);
			if (rows[i].st[0]) begin
				chk(setup_data, sd);
				chk({data_stage, data_in}, {xt[1], xt == 2'h3});
				rd(ssd_pkg::REG_SETUP_HI);
				chk(v, sd[63:32]);
				rd(ssd_pkg::REG_INFO);
				chk(v, {20'h00000, it, 2'h3});
				@(posedge clk_sys);
				desc_done <= 1;
				@(posedge clk_sys);
				desc_done <= 0;
				#1 chk(event_valid, 1);
				chk(event_intr, it);
			end
			rd(ssd_pkg::REG_STATUS);
			chk(v, rows[i].st);
			chk(irq, 0);
			wr(ssd_pkg::REG_STATUS, 32'h0000001F);
		end
		// expected cycle flipped: a stale descriptor must wait
		wr(ssd_pkg::REG_CTRL, 32'h00000000);
		wr(ssd_pkg::REG_MASK, 32'h00000001);
		@(posedge clk_sys);
		{flt, compl} <= '0;
		send();
		chk(setup_valid, 0);
		@(posedge clk_sys);
		cy <= 0;
		send();
		chk(setup_valid, 1);
		@(posedge clk_sys);
		desc_done <= 1;
		#1 chk(irq, 1);
		@(posedge clk_sys);
		desc_done <= 0;
		#1 chk(event_valid, 0);
		// reset with irq and status still up: both must drop
		@(posedge clk_sys);
		rst <= 1;
		@(posedge clk_sys);
		#1 chk(irq, 0);
		chk(setup_data, 64'h0000000000000000);
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		rd(ssd_pkg::REG_STATUS);
		chk(v, 32'h00000000);
		rd(ssd_pkg::REG_CTRL);
		chk(v, 1);
		rd(ssd_pkg::REG_MASK);
		chk(v, 0);
		rd(8'h18);
		chk(v, 0);
		complete_run();
	end
endmodule : test_ssd_decoder
`default_nettype wire
